// >>> fpric_core.sv
// Function
// - Interlocked store drives flag pin zero high at execute start.
// - Store address put out at execute unless a conflict delays it.
// - Signal interlock: flag zero low, sample flag one, then flag zero high.
// - Interlocked load: flag zero low, then sample flag one.
// - Output bits at 2 and 6 reach the pin one cycle after write.
// - Direction bits at 1 and 5, read-only input bits at 3 and 7.
// - Direction change takes effect one cycle after the write.
// - Reset loads seven wait states into the bus control register.
// - Hold request during reset is granted within nine cycles.
// - Reset floats flag, serial and timer pins at once.
// - Reset floats address, page and data; strobes, rw, ack high.
// - After reset the vector is fetched twice, wait states by mode.
// - Phase clock derivation by mode lies outside this block.
// - A missed input setup may add one cycle of delay.
// - Four interrupt inputs sampled each cycle, level or edge mode.
// - Interrupts are acted on only at fetch boundaries.
// - Edge mode detects falling edges synchronously.
// - A flag may set again two cycles after being cleared.
// - A clear and a detection at the same edge: clear wins.
// - Acknowledge low in decode phase, high again in read phase.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpric_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Flag pins
  input wire logic i_flag_pin_zero,
  input wire logic i_flag_pin_one,
  output fpric_pkg::fpric_pin_s o_flag_pin_zero,
  output fpric_pkg::fpric_pin_s o_flag_pin_one,
  // Interrupts and hold
  input wire logic [3:0] i_ext_int_n,
  input wire logic i_hold_req_n,
  input wire logic i_fetch_boundary,
  output logic [3:0] o_int_taken,
  output logic o_hold_grant_out_n,
  output logic o_int_ack_out_n,
  // Bus side effects
  output logic o_store_addr_drive,
  output logic o_bus_float,
  output logic o_ctrl_high,
  output logic o_periph_float,
  output logic [1:0] o_vector_fetch_cnt
);

  // One clock edge stands for each phase clock edge
  logic [7:0] flag_ctrl_q;
  logic edge_sel_q;
  logic [3:0] int_flag_q;
  logic [2:0] bus_wait_q;
  logic [1:0] sync_f0_q, sync_f1_q;
  logic [3:0] int_s1_q, int_s2_q, int_prev_q;
  logic hold_s1_q, hold_s2_q;
  logic [3:0] hold_cnt_q;
  logic ack_q;
  logic [1:0] ack_phase_q;
  logic store_pend_q;
  logic in_reset_q;
  logic [1:0] vec_q;
  logic flag1_sampled_q;
  fpric_pkg::fpric_seq_e seq_q;
  logic seq_is_signal_q;

  logic wr_en, rd_en;
  logic [3:0] int_detect, int_clear;
  logic cmd_store, cmd_load, cmd_signal, cmd_ack, cmd_conflict;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  assign wr_en = i_psel & i_penable & i_pwrite;
  // Read data is captured in the setup cycle so it stands at the access edge
  assign rd_en = i_psel & ~i_penable & ~i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;
  assign cmd_store = wr_en & reg_hit(i_paddr, fpric_pkg::CPU_CMD_OFS) & i_pwdata[fpric_pkg::CMD_STORE_BIT];
  assign cmd_load = wr_en & reg_hit(i_paddr, fpric_pkg::CPU_CMD_OFS) & i_pwdata[fpric_pkg::CMD_LOAD_BIT];
  assign cmd_signal = wr_en & reg_hit(i_paddr, fpric_pkg::CPU_CMD_OFS) & i_pwdata[fpric_pkg::CMD_SIGNAL_BIT];
  assign cmd_ack = wr_en & reg_hit(i_paddr, fpric_pkg::CPU_CMD_OFS) & i_pwdata[fpric_pkg::CMD_ACK_BIT];
  assign cmd_conflict = wr_en & reg_hit(i_paddr, fpric_pkg::CPU_CMD_OFS) & i_pwdata[fpric_pkg::CMD_CONFLICT_BIT];

  // Pin synchronisers; a missed setup just costs one more cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync_f0_q <= 2'h0;
      sync_f1_q <= 2'h0;
      int_s1_q <= 4'hF;
      int_s2_q <= 4'hF;
      int_prev_q <= 4'hF;
    end else begin
      sync_f0_q <= {sync_f0_q[0], i_flag_pin_zero};
      sync_f1_q <= {sync_f1_q[0], i_flag_pin_one};
      int_s1_q <= i_ext_int_n;
      int_s2_q <= int_s1_q;
      int_prev_q <= int_s2_q;
    end
  end

  // Hold chain keeps running through reset so a grant can come during reset
  always_ff @(posedge i_clk) begin
    hold_s1_q <= i_hold_req_n;
    hold_s2_q <= hold_s1_q;
  end

  // Reset tracking; vector fetched twice after release
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      in_reset_q <= 1'b1;
      vec_q <= 2'h0;
    end else begin
      in_reset_q <= 1'b0;
      if (vec_q != 2'h2) begin
        vec_q <= vec_q + 2'h1;
      end
    end
  end
  assign o_vector_fetch_cnt = vec_q;

  // Reset pin states
  assign o_periph_float = i_reset | in_reset_q;
  assign o_bus_float = i_reset | in_reset_q;
  assign o_ctrl_high = i_reset | in_reset_q;

  // Hold grant, honoured during reset too
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_cnt_q <= 4'h0;
    end else if (hold_s2_q) begin
      hold_cnt_q <= 4'h0;
    end else if (hold_cnt_q != fpric_pkg::HOLD_GRANT_MAX) begin
      hold_cnt_q <= hold_cnt_q + 4'h1;
    end
  end
  // Grant comes from the sync chain, well within nine cycles
  assign o_hold_grant_out_n = hold_s2_q;

  // Flag control register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_ctrl_q <= fpric_pkg::FLAG_CTRL_RST;
    end else begin
      if (wr_en && reg_hit(i_paddr, fpric_pkg::FLAG_CTRL_OFS)) begin
        flag_ctrl_q[fpric_pkg::FLAG0_DIR_BIT] <= i_pwdata[fpric_pkg::FLAG0_DIR_BIT];
        flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT] <= i_pwdata[fpric_pkg::FLAG0_OUT_BIT];
        flag_ctrl_q[fpric_pkg::FLAG1_DIR_BIT] <= i_pwdata[fpric_pkg::FLAG1_DIR_BIT];
        flag_ctrl_q[fpric_pkg::FLAG1_OUT_BIT] <= i_pwdata[fpric_pkg::FLAG1_OUT_BIT];
      end
      if (cmd_store) begin
        flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT] <= 1'b1;
      end else if (seq_q == fpric_pkg::SEQ_IDLE && (cmd_load || cmd_signal)) begin
        flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT] <= 1'b0;
      end else if (seq_q == fpric_pkg::SEQ_SAMPLE && seq_is_signal_q) begin
        flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT] <= 1'b1;
      end
    end
  end

  // Interlock sequencer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seq_q <= fpric_pkg::SEQ_IDLE;
      seq_is_signal_q <= 1'b0;
      flag1_sampled_q <= 1'b0;
    end else begin
      case (seq_q)
        fpric_pkg::SEQ_IDLE: begin
          if (cmd_load || cmd_signal) begin
            seq_q <= fpric_pkg::SEQ_LOW;
            seq_is_signal_q <= cmd_signal;
          end
        end
        fpric_pkg::SEQ_LOW: begin
          seq_q <= fpric_pkg::SEQ_SAMPLE;
        end
        fpric_pkg::SEQ_SAMPLE: begin
          flag1_sampled_q <= sync_f1_q[1];
          seq_q <= seq_is_signal_q ? fpric_pkg::SEQ_HIGH : fpric_pkg::SEQ_IDLE;
        end
        fpric_pkg::SEQ_HIGH: begin
          seq_q <= fpric_pkg::SEQ_IDLE;
        end
        default: begin
          seq_q <= fpric_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Store address drive, held back by a pipeline conflict
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      store_pend_q <= 1'b0;
      o_store_addr_drive <= 1'b0;
    end else begin
      o_store_addr_drive <= (cmd_store && !cmd_conflict) || (store_pend_q && !cmd_conflict);
      if (cmd_store && cmd_conflict) begin
        store_pend_q <= 1'b1;
      end else if (!cmd_conflict) begin
        store_pend_q <= 1'b0;
      end
    end
  end

  // Pin drive
  always_comb begin
    o_flag_pin_zero.o = flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT];
    o_flag_pin_zero.oe = flag_ctrl_q[fpric_pkg::FLAG0_DIR_BIT] & ~o_periph_float;
    o_flag_pin_one.o = flag_ctrl_q[fpric_pkg::FLAG1_OUT_BIT];
    o_flag_pin_one.oe = flag_ctrl_q[fpric_pkg::FLAG1_DIR_BIT] & ~o_periph_float;
  end

  // Interrupt control and bus control registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      edge_sel_q <= 1'b0;
      bus_wait_q <= fpric_pkg::BUS_WAIT_RST;
    end else begin
      if (wr_en && reg_hit(i_paddr, fpric_pkg::INT_CTRL_OFS)) begin
        edge_sel_q <= i_pwdata[fpric_pkg::EDGE_SEL_BIT];
      end
      if (wr_en && reg_hit(i_paddr, fpric_pkg::BUS_CTRL_OFS)) begin
        bus_wait_q <= i_pwdata[2:0];
      end
    end
  end

  assign int_detect = edge_sel_q ? (int_prev_q & ~int_s2_q) : ~int_s2_q;
  assign int_clear = (wr_en && reg_hit(i_paddr, fpric_pkg::INT_FLAG_OFS)) ? i_pwdata[3:0] : 4'h0;

  // Interrupt flags: write one to clear, clear beats a same-cycle detect
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      int_flag_q <= 4'h0;
    end else begin
      int_flag_q <= (int_flag_q | int_detect) & ~int_clear;
    end
  end

  // Hand flags to the CPU only at fetch boundaries
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_int_taken <= 4'h0;
    end else begin
      o_int_taken <= i_fetch_boundary ? int_flag_q : 4'h0;
    end
  end

  // Acknowledge pulse: low for decode phase, high at read phase
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ack_q <= 1'b1;
      ack_phase_q <= 2'h0;
    end else if (cmd_ack && ack_phase_q == 2'h0) begin
      ack_q <= 1'b0;
      ack_phase_q <= 2'h1;
    end else if (ack_phase_q == 2'h1) begin
      ack_q <= 1'b1;
      ack_phase_q <= 2'h0;
    end
  end
  assign o_int_ack_out_n = ack_q | in_reset_q;

  // Read mux
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (i_paddr)
        fpric_pkg::FLAG_CTRL_OFS: begin
          o_prdata <= {24'h00_0000, sync_f1_q[1], flag_ctrl_q[6:4], sync_f0_q[1], flag_ctrl_q[2:0]};
        end
        fpric_pkg::INT_CTRL_OFS: o_prdata <= {31'h0000_0000, edge_sel_q};
        fpric_pkg::INT_FLAG_OFS: o_prdata <= {28'h000_0000, int_flag_q};
        fpric_pkg::STATUS_OFS: begin
          o_prdata <= {25'h000_0000, flag1_sampled_q, hold_cnt_q == fpric_pkg::HOLD_GRANT_MAX, vec_q, store_pend_q,
                       1'b0, seq_q != fpric_pkg::SEQ_IDLE};
        end
        fpric_pkg::BUS_CTRL_OFS: o_prdata <= {29'h0000_0000, bus_wait_q};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  property p_store_high;
    @(posedge i_clk) disable iff (i_reset) cmd_store |=> flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT];
  endproperty
  a_store_high: assert property (p_store_high) else $error("store did not raise flag zero");
  property p_sig_seq;
    @(posedge i_clk) disable iff (i_reset)
      (seq_q == fpric_pkg::SEQ_IDLE && cmd_signal && !cmd_store)
      |=> !flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT] ##2 flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT];
  endproperty
  a_sig_seq: assert property (p_sig_seq) else $error("signal sequence wrong");
  property p_load_low;
    @(posedge i_clk) disable iff (i_reset)
      (seq_q == fpric_pkg::SEQ_IDLE && cmd_load && !cmd_signal && !cmd_store) |=> !flag_ctrl_q[fpric_pkg::FLAG0_OUT_BIT];
  endproperty
  a_load_low: assert property (p_load_low) else $error("load did not lower flag zero");
  property p_pin_oe;
    @(posedge i_clk) disable iff (i_reset) o_flag_pin_zero.oe |-> flag_ctrl_q[fpric_pkg::FLAG0_DIR_BIT];
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("flag zero driven as input");
  property p_clear_wins;
    @(posedge i_clk) disable iff (i_reset) int_clear[0] |=> !int_flag_q[0];
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("clear lost to detect");
  property p_ack_pulse;
    @(posedge i_clk) disable iff (i_reset) $fell(ack_q) |=> ack_q;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack pulse not one cycle");
  property p_hold;
    @(posedge i_clk) $fell(i_hold_req_n) |-> ##[1:9] !o_hold_grant_out_n;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not granted in nine cycles");
  property p_taken;
    @(posedge i_clk) disable iff (i_reset) !i_fetch_boundary |=> o_int_taken == 4'h0;
  endproperty
  a_taken: assert property (p_taken) else $error("interrupt taken off boundary");
  property p_store_addr;
    @(posedge i_clk) disable iff (i_reset) (cmd_store && !cmd_conflict) |=> o_store_addr_drive;
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address not driven");
  property p_store_hold;
    @(posedge i_clk) disable iff (i_reset) (cmd_store && cmd_conflict) |=> !o_store_addr_drive && store_pend_q;
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store address not held back");
  property p_out_pin;
    @(posedge i_clk) disable iff (i_reset)
      (wr_en && i_paddr == fpric_pkg::FLAG_CTRL_OFS && !(seq_q == fpric_pkg::SEQ_SAMPLE && seq_is_signal_q))
      |=> o_flag_pin_zero.o == $past(i_pwdata[fpric_pkg::FLAG0_OUT_BIT])
          && o_flag_pin_zero.oe == $past(i_pwdata[fpric_pkg::FLAG0_DIR_BIT]);
  endproperty
  a_out_pin: assert property (p_out_pin) else $error("flag zero pin not following register");
  property p_reset_outs;
    @(posedge i_clk) disable iff (i_reset)
      in_reset_q |-> o_periph_float && o_bus_float && o_ctrl_high && o_int_ack_out_n;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("reset pin states wrong");
  property p_vec_seq;
    @(posedge i_clk) disable iff (i_reset) in_reset_q |=> o_vector_fetch_cnt == 2'h1 ##1 o_vector_fetch_cnt == 2'h2;
  endproperty
  a_vec_seq: assert property (p_vec_seq) else $error("vector not fetched twice");
  property p_wait_reset;
    @(posedge i_clk) disable iff (i_reset) in_reset_q |-> bus_wait_q == fpric_pkg::BUS_WAIT_RST;
  endproperty
  a_wait_reset: assert property (p_wait_reset) else $error("wait states not at reset value");
  property p_level_set;
    @(posedge i_clk) disable iff (i_reset) (!edge_sel_q && !int_s2_q[0] && !int_clear[0]) |=> int_flag_q[0];
  endproperty
  a_level_set: assert property (p_level_set) else $error("level interrupt not flagged");
  property p_edge_only;
    @(posedge i_clk) disable iff (i_reset)
      (edge_sel_q && !int_flag_q[0] && !(int_prev_q[0] && !int_s2_q[0])) |=> !int_flag_q[0];
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("edge flag set without falling edge");
  c_sig: cover property (@(posedge i_clk) disable iff (i_reset) seq_q == fpric_pkg::SEQ_HIGH);
  c_ack: cover property (@(posedge i_clk) disable iff (i_reset) $fell(ack_q));
  c_int: cover property (@(posedge i_clk) disable iff (i_reset) |int_flag_q);
  c_store_pend: cover property (@(posedge i_clk) disable iff (i_reset) store_pend_q);
  c_edge: cover property (@(posedge i_clk) disable iff (i_reset) edge_sel_q && |int_flag_q);

endmodule
`default_nettype wire

// >>> fpric_pkg.sv
package fpric_pkg;

  // APB register byte offsets
  localparam logic [7:0] FLAG_CTRL_OFS = 8'h00;
  localparam logic [7:0] INT_CTRL_OFS = 8'h04;
  localparam logic [7:0] INT_FLAG_OFS = 8'h08;
  localparam logic [7:0] CPU_CMD_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] BUS_CTRL_OFS = 8'h14;

  // Flag control register fields
  localparam int FLAG0_DIR_BIT = 1;
  localparam int FLAG0_OUT_BIT = 2;
  localparam int FLAG0_IN_BIT = 3;
  localparam int FLAG1_DIR_BIT = 5;
  localparam int FLAG1_OUT_BIT = 6;
  localparam int FLAG1_IN_BIT = 7;

  // Interrupt control fields
  localparam int EDGE_SEL_BIT = 0;

  // Command register fields (write-one pulses)
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int CMD_SIGNAL_BIT = 2;
  localparam int CMD_ACK_BIT = 3;
  localparam int CMD_CONFLICT_BIT = 4;

  // Reset values and cycle counts
  localparam logic [7:0] FLAG_CTRL_RST = 8'h00;
  localparam logic [2:0] BUS_WAIT_RST = 3'h7;
  localparam logic [3:0] HOLD_GRANT_MAX = 4'h9;
  localparam logic [3:0] RESET_MIN_CYC = 4'hA;
  localparam logic [1:0] REFLAG_CYC = 2'h2;

  typedef enum {SEQ_IDLE, SEQ_LOW, SEQ_SAMPLE, SEQ_HIGH} fpric_seq_e;

  typedef struct packed {
    logic o;
    logic oe;
  } fpric_pin_s;

endpackage

// >>> fpric_peer.sv
`timescale 1ns/1ps
`default_nettype none
module fpric_peer (
  // Clock and requests from the bench
  input wire logic i_clk,
  input wire logic [3:0] i_go,
  input wire logic [3:0] i_len,
  input wire logic i_flag_one_val,
  // Device pins
  input wire fpric_pkg::fpric_pin_s i_pin_zero,
  input wire fpric_pkg::fpric_pin_s i_pin_one,
  output logic [3:0] o_int_n,
  output logic o_lvl_zero,
  output logic o_lvl_one
);
  logic [3:0] cnt_q [4] = '{default: 4'h0};
  // Released pins: pull-up on flag zero, peer drives flag one
  assign o_lvl_zero = i_pin_zero.oe ? i_pin_zero.o : 1'b1;
  assign o_lvl_one = i_pin_one.oe ? i_pin_one.o : i_flag_one_val;
  // Each low pulse lasts exactly the requested number of cycles
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (i_go[i]) cnt_q[i] <= i_len;
      else if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) o_int_n[i] = (cnt_q[i] == 4'h0);
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, hold_n = 1'b1, fb = 1'b0, fval = 1'b1;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, prd, rdv, v;
  logic [3:0] go = 4'h0, len = 4'h0, intn, taken;
  logic prdy, perr, lz, lo, ackn, grn, st, bfl, chi, pfl;
  logic [1:0] vcnt;
  fpric_pkg::fpric_pin_s fz, fo;
  int err_count = 0, check_count = 0, lo0 = 0, ackc = 0, stc = 0, n;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    lo0 += (lz === 1'b0);
    ackc += (ackn === 1'b0);
    stc += (st === 1'b1);
  end
  fpric_core dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .i_flag_pin_zero(lz), .i_flag_pin_one(lo), .o_flag_pin_zero(fz), .o_flag_pin_one(fo),
    .i_ext_int_n(intn), .i_hold_req_n(hold_n), .i_fetch_boundary(fb), .o_int_taken(taken),
    .o_hold_grant_out_n(grn), .o_int_ack_out_n(ackn), .o_store_addr_drive(st), .o_bus_float(bfl),
    .o_ctrl_high(chi), .o_periph_float(pfl), .o_vector_fetch_cnt(vcnt));
  fpric_peer peer_u (.i_clk(i_clk), .i_go(go), .i_len(len), .i_flag_one_val(fval), .i_pin_zero(fz),
    .i_pin_one(fo), .o_int_n(intn), .o_lvl_zero(lz), .o_lvl_one(lo));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= wr;
    padr <= a;
    pwd <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    rdv = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      err_count++;
      $display("ERROR %0t bus wait timed out", $time);
      stop_test();
    end
  endtask
  task automatic pulse(input logic [3:0] g, input logic [3:0] l);
    @(posedge i_clk);
    go <= g;
    len <= l;
    @(posedge i_clk);
    go <= 4'h0;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  initial begin
    cyc(20000);
    err_count++;
    $display("ERROR %0t run timed out", $time);
    stop_test();
  end
  initial begin
    void'($urandom(32'h179496bd));
    cyc(1);
    chk(32'({fz.oe, fo.oe, ackn, bfl, chi, pfl}), 32'h0000_000F, "reset pins");
    @(posedge i_clk);
    i_reset <= 1'b0;
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk(rdv, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      v = $urandom & 32'h0000_0066;
      fval <= 1'($urandom);
      apb(1'b1, 8'h00, v);
      cyc(1);
      chk(32'({fz.oe, fz.o, fo.oe, fo.o}), 32'({v[1], v[2], v[5], v[6]}), "flag pins");
      cyc(3);
      apb(1'b0, 8'h00, 32'h0000_0000);
      v[3] = v[1] ? v[2] : 1'b1;
      v[7] = v[5] ? v[6] : fval;
      chk(rdv & 32'h0000_00EE, v, "flag register");
    end
    $display("test flag pins done");
    apb(1'b1, 8'h00, 32'h0000_0002);
    n = stc;
    apb(1'b1, 8'h0C, 32'h0000_0001);
    cyc(3);
    chk(32'(lz), 32'h0000_0001, "store flag high");
    chk(32'(stc - n), 32'h0000_0001, "store address");
    n = stc;
    apb(1'b1, 8'h0C, 32'h0000_0011);
    cyc(3);
    chk(32'(stc - n), 32'h0000_0001, "late store address");
    apb(1'b1, 8'h00, 32'h0000_0006);
    n = lo0;
    apb(1'b1, 8'h0C, 32'h0000_0004);
    cyc(6);
    chk(32'((lo0 - n) inside {[1:3]} && lz === 1'b1), 32'h0000_0001, "signal flag");
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(rdv[6]), 32'(fval), "signal sample");
    n = lo0;
    apb(1'b1, 8'h0C, 32'h0000_0002);
    cyc(4);
    chk(32'(lo0 > n), 32'h0000_0001, "load flag low");
    for (int k = 0; k < 2; k++) begin
      n = ackc;
      apb(1'b1, 8'h0C, 32'h0000_0008);
      cyc(4);
      chk(32'(ackc - n), 32'h0000_0001, "ack pulse");
    end
    $display("test commands done");
    apb(1'b1, 8'h04, 32'h0000_0000);
    pulse(4'hF, 4'h2);
    cyc(4);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rdv & 32'h0000_000F, 32'h0000_000F, "level flags");
    chk(32'(taken), 32'h0000_0000, "no boundary");
    @(posedge i_clk);
    fb <= 1'b1;
    @(posedge i_clk);
    fb <= 1'b0;
    #1;
    n = 0;
    while (taken !== 4'hF && n < 3) begin
      cyc(1);
      n++;
    end
    chk(32'(taken), 32'h0000_000F, "boundary taken");
    apb(1'b1, 8'h08, 32'h0000_000F);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rdv & 32'h0000_000F, 32'h0000_0000, "cleared");
    pulse(4'hF, 4'h1);
    cyc(4);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rdv & 32'h0000_000F, 32'h0000_000F, "set again");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h04, 32'(m));
      apb(1'b1, 8'h08, 32'h0000_000F);
      pulse(4'h1, 4'h8);
      cyc(3);
      apb(1'b1, 8'h08, 32'h0000_0001);
      cyc(8);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(32'(rdv[0]), 32'(m == 0), "clear while low");
    end
    pulse(4'h2, 4'h4);
    cyc(5);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(32'(rdv[1]), 32'h0000_0001, "edge detect");
    $display("test interrupts done");
    apb(1'b1, 8'h14, 32'h0000_0000);
    @(posedge i_clk);
    hold_n <= 1'b0;
    i_reset <= 1'b1;
    cyc(5);
    chk(32'({grn, fz.oe, fo.oe, ackn, bfl, chi, pfl}), 32'h0000_000F, "mid reset pins");
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    n = 0;
    while (grn !== 1'b0 && n < 9) begin
      cyc(1);
      n++;
    end
    chk(32'(grn), 32'h0000_0000, "hold grant");
    @(posedge i_clk);
    hold_n <= 1'b1;
    n = 0;
    while (vcnt !== 2'd2 && n < 30) begin
      cyc(1);
      n++;
    end
    chk(32'(vcnt), 32'h0000_0002, "vector fetches");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(rdv & 32'h0000_0007, 32'h0000_0007, "wait states");
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
